// *** verilog/iocx_params.svh ***
// Constants for the I/O command and expanded control decoder
`ifndef IOCX_PARAMS_SVH
`define IOCX_PARAMS_SVH
`define IOCX_W_IO_COMMAND_FIELD 2
`define IOCX_W_EXPANDED_CONTROL_FIELD 4
`define IOCX_W_BITSEL 3
`define IOCX_W_DATA 16
`define IOCX_N_FLAGS 8
`define IOCX_FIFO_DEPTH 4
`define IOCX_W_PTR 2
`define IOCX_W_CNT 3
`define IOCX_N_EVT 5
`define IOCX_IO_COMMAND_FIELD_NOP 2'h0
`define IOCX_IO_COMMAND_FIELD_RD 2'h1
`define IOCX_IO_COMMAND_FIELD_WR 2'h2
`define IOCX_IO_COMMAND_FIELD_DEV 2'h3
`define IOCX_EXP_NOP 4'h0
`define IOCX_EXP_CLRF 4'h1
`define IOCX_EXP_RSTF 4'h2
`define IOCX_EXP_ADVF 4'h3
`define IOCX_EXP_SETF 4'h4
`define IOCX_EXP_SOFT_INTERRUPT_OP 4'h5
`define IOCX_EXP_INTERRUPT_ENABLE_OP 4'h6
`define IOCX_ADDR_CTRL 12'h000
`define IOCX_ADDR_FLAGS 12'h004
`define IOCX_ADDR_STATUS 12'h008
`define IOCX_ADDR_MASK 12'h00C
`define IOCX_ADDR_FIFO 12'h010
`define IOCX_EVT_RD_DONE 0
`define IOCX_EVT_WR_DONE 1
`define IOCX_EVT_AVAIL 2
`define IOCX_EVT_SOFT_INTERRUPT_OP_EXEC 3
`define IOCX_EVT_OVERRUN 4
`define IOCX_RST_MASK 5'h00
`endif

// *** verilog/iocx_pkg.sv ***
// Types shared by the I/O command and expanded control decoder
package iocx_pkg;
  typedef enum logic [2:0] {
    DMA_IDLE = 3'b000,
    DMA_RD_REQ = 3'b001,
    DMA_RD_WAIT = 3'b010,
    DMA_RD_DATA = 3'b011,
    DMA_WR_REQ = 3'b100
  } dma_state_e;

  typedef struct packed {
    logic [1:0] io_command_field;
    logic [3:0] expanded_control_field;
    logic [2:0] bit_select;
    logic [15:0] alu_out;
  } instr_s;

  typedef struct packed {
    dma_state_e st;
    logic [15:0] addr;
    logic req;
    logic wr;
    logic [15:0] wdata;
    logic [15:0] dev_ctrl;
    logic [7:0] flags;
    logic [7:0] pend;
    logic int_en;
    logic exec_v;
    logic [2:0] exec_idx;
    logic [3:0][15:0] mem;
    logic [1:0] rd_ptr;
    logic [1:0] wr_ptr;
    logic [2:0] count;
    logic [15:0] out_data;
    logic data_valid;
    logic full;
    logic in_ready;
    logic avail;
    logic [4:0] status;
    logic [4:0] mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } iocx_state_s;
endpackage

// *** verilog/io_command_expanded_control_field_decoder.sv ***
// I/O command and expanded control field decoder with host DMA sequencer
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "iocx_params.svh"

// Functional notes
// - Command 1 starts DMA read at ALU address
// - Read: request, acknowledge, wait, strobe loads word
// - Data available asserted if FIFO was empty
// - Command 2 starts DMA write at ALU address
// - Write request takes output buffer; acknowledge completes
// - Written word in memory when acknowledge is given
// - Command 3 loads device control from ALU
// - Device control register never read back
// - Expanded 1 clears the selected flag
// - Expanded 2 resets pointers, valid, full
// - First word after reset falls through, valid
// - Expanded 3 advances read pointer, reloads buffer
// - Advance leaving FIFO empty drops valid
// - Expanded 4 sets the selected flag
// - Expanded 5 sets interrupt; runs two later
// - Expanded 6 enables interrupts; pending run next
// - All fields of one word act together
module io_command_expanded_control_field_decoder
  import iocx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire instr_s instr,
  input wire logic fifo_in_valid,
  input wire logic [15:0] fifo_in_data,
  output logic fifo_in_ready,
  output logic [15:0] fifo_out_data,
  output logic data_valid,
  output logic fifo_full,
  output logic data_available,
  output logic dma_channel_request,
  output logic dma_write_dir,
  output logic [15:0] host_memory_address,
  output logic [15:0] dma_write_data,
  input wire logic dma_channel_ack,
  input wire logic dma_data_strobe,
  input wire logic [15:0] dma_read_data,
  output logic [15:0] device_control_reg,
  output logic [7:0] flags,
  output logic int_exec_valid,
  output logic [2:0] int_exec_index,
  output logic irq
);

  iocx_state_s s_q;
  iocx_state_s s_d;

  // One-hot select of a flag or interrupt by bit-select field
  function automatic logic [7:0] sel_bit(input logic [2:0] idx);
    sel_bit = 8'h01 << idx;
  endfunction

  function automatic logic [2:0] lowest(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    lowest = r;
  endfunction

  logic [1:0] ioc;
  logic [3:0] exp;
  logic [7:0] bsel;
  logic apb_acc;
  logic apb_wr;
  logic [4:0] evt;
  logic push_dma;
  logic push_ext;
  logic [2:0] cnt;
  logic [1:0] rp;
  logic [1:0] wp;
  logic [3:0][15:0] mem;
  logic en_now;

  assign apb_acc = psel & penable & s_q.pready;
  assign apb_wr = apb_acc & pwrite;

  always_comb begin
    s_d = s_q;
    ioc = instr_valid ? instr.io_command_field : `IOCX_IO_COMMAND_FIELD_NOP;
    exp = instr_valid ? instr.expanded_control_field : `IOCX_EXP_NOP;
    bsel = sel_bit(instr.bit_select);
    evt = 5'h00;
    push_dma = 1'b0;
    push_ext = fifo_in_valid & s_q.in_ready;

    // DMA sequencer
    unique case (s_q.st)
      DMA_IDLE: begin
        if (ioc == `IOCX_IO_COMMAND_FIELD_RD) begin
          s_d.st = DMA_RD_REQ;
          s_d.addr = instr.alu_out;
          s_d.req = 1'b1;
          s_d.wr = 1'b0;
        end
        if (ioc == `IOCX_IO_COMMAND_FIELD_WR) begin
          s_d.st = DMA_WR_REQ;
          s_d.addr = instr.alu_out;
          s_d.req = 1'b1;
          s_d.wr = 1'b1;
          s_d.wdata = s_q.out_data;
        end
      end
      DMA_RD_REQ: begin
        if (dma_channel_ack) begin
          s_d.req = 1'b0;
          s_d.st = DMA_RD_WAIT;
        end
      end
      DMA_RD_WAIT: begin
        s_d.st = DMA_RD_DATA;
      end
      DMA_RD_DATA: begin
        if (dma_data_strobe) begin
          push_dma = 1'b1;
          s_d.st = DMA_IDLE;
          evt[`IOCX_EVT_RD_DONE] = 1'b1;
        end
      end
      DMA_WR_REQ: begin
        if (dma_channel_ack) begin
          s_d.req = 1'b0;
          s_d.wr = 1'b0;
          s_d.st = DMA_IDLE;
          evt[`IOCX_EVT_WR_DONE] = 1'b1;
        end
      end
      default: begin
        s_d.st = DMA_IDLE;
        s_d.req = 1'b0;
      end
    endcase
    if (s_q.st != DMA_IDLE &&
        (ioc == `IOCX_IO_COMMAND_FIELD_RD || ioc == `IOCX_IO_COMMAND_FIELD_WR)) begin
      evt[`IOCX_EVT_OVERRUN] = 1'b1;
    end

    if (ioc == `IOCX_IO_COMMAND_FIELD_DEV) begin
      s_d.dev_ctrl = instr.alu_out;
    end

    if (exp == `IOCX_EXP_CLRF) begin
      s_d.flags = s_q.flags & ~bsel;
    end
    if (exp == `IOCX_EXP_SETF) begin
      s_d.flags = s_q.flags | bsel;
    end

    // FIFO: reset or advance first, then pushes
    cnt = s_q.count;
    rp = s_q.rd_ptr;
    wp = s_q.wr_ptr;
    mem = s_q.mem;
    if (exp == `IOCX_EXP_RSTF) begin
      cnt = 3'h0;
      rp = 2'h0;
      wp = 2'h0;
    end
    if (exp == `IOCX_EXP_ADVF && cnt != 3'h0) begin
      cnt = cnt - 3'h1;
      rp = rp + 2'h1;
    end
    if (cnt == 3'h0 && (push_dma || push_ext)) begin
      evt[`IOCX_EVT_AVAIL] = 1'b1;
    end
    if (push_dma) begin
      if (cnt == 3'(`IOCX_FIFO_DEPTH)) begin
        evt[`IOCX_EVT_OVERRUN] = 1'b1;
      end else begin
        mem[wp] = dma_read_data;
        wp = wp + 2'h1;
        cnt = cnt + 3'h1;
      end
    end
    if (push_ext && cnt != 3'(`IOCX_FIFO_DEPTH)) begin
      mem[wp] = fifo_in_data;
      wp = wp + 2'h1;
      cnt = cnt + 3'h1;
    end
    s_d.mem = mem;
    s_d.count = cnt;
    s_d.rd_ptr = rp;
    s_d.wr_ptr = wp;
    s_d.out_data = mem[rp];
    s_d.data_valid = (cnt != 3'h0);
    s_d.full = (cnt == 3'(`IOCX_FIFO_DEPTH));
    // Room kept for a DMA word arriving with an external one
    s_d.in_ready = (cnt < 3'(`IOCX_FIFO_DEPTH - 1));
    s_d.avail = evt[`IOCX_EVT_AVAIL];

    // Interrupt execution; software may also enable via register
    en_now = s_q.int_en;
    if (exp == `IOCX_EXP_INTERRUPT_ENABLE_OP) begin
      en_now = 1'b1;
      s_d.int_en = 1'b1;
    end
    if (apb_wr && paddr == `IOCX_ADDR_CTRL) begin
      s_d.int_en = pwdata[0];
    end
    s_d.exec_v = 1'b0;
    if (en_now && s_q.pend != 8'h00) begin
      s_d.exec_v = 1'b1;
      s_d.exec_idx = lowest(s_q.pend);
      s_d.pend = s_q.pend & ~sel_bit(lowest(s_q.pend));
      evt[`IOCX_EVT_SOFT_INTERRUPT_OP_EXEC] = 1'b1;
    end
    if (exp == `IOCX_EXP_SOFT_INTERRUPT_OP) begin
      s_d.pend = s_d.pend | bsel;
    end

    // APB: one wait cycle, answer in the second access cycle
    s_d.pready = psel & penable & ~s_q.pready;
    s_d.pslverr = 1'b0;
    s_d.prdata = 32'h0000_0000;
    if (psel & penable & ~s_q.pready) begin
      unique case (paddr)
        `IOCX_ADDR_CTRL: s_d.prdata = {31'h0, s_q.int_en};
        `IOCX_ADDR_FLAGS: s_d.prdata = {24'h0, s_q.flags};
        `IOCX_ADDR_STATUS: s_d.prdata = {27'h0, s_q.status};
        `IOCX_ADDR_MASK: s_d.prdata = {27'h0, s_q.mask};
        `IOCX_ADDR_FIFO: s_d.prdata = {24'h0, s_q.st, s_q.full, s_q.data_valid, s_q.count};
        default: s_d.pslverr = 1'b1;
      endcase
    end
    if (apb_wr && paddr == `IOCX_ADDR_FLAGS) begin
      s_d.flags = pwdata[7:0];
    end
    if (apb_wr && paddr == `IOCX_ADDR_MASK) begin
      s_d.mask = pwdata[4:0];
    end
    // Set wins over a write-one clear in the same cycle
    s_d.status = s_q.status;
    if (apb_wr && paddr == `IOCX_ADDR_STATUS) begin
      s_d.status = s_q.status & ~pwdata[4:0];
    end
    s_d.status = s_d.status | evt;
    s_d.irq = |(s_d.status & s_d.mask);
  end

  // all fields land on one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{st: DMA_IDLE, mask: `IOCX_RST_MASK, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign fifo_in_ready = s_q.in_ready;
  assign fifo_out_data = s_q.out_data;
  assign data_valid = s_q.data_valid;
  assign fifo_full = s_q.full;
  assign data_available = s_q.avail;
  assign dma_channel_request = s_q.req;
  assign dma_write_dir = s_q.wr;
  assign host_memory_address = s_q.addr;
  assign dma_write_data = s_q.wdata;
  assign device_control_reg = s_q.dev_ctrl;
  assign flags = s_q.flags;
  assign int_exec_valid = s_q.exec_v;
  assign int_exec_index = s_q.exec_idx;
  assign irq = s_q.irq;

endmodule

// *** tb/iocx_checker.sv ***
// Port assertions for the decoder
`timescale 1ns/1ps
module iocx_checker
  import iocx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic instr_valid,
  input wire instr_s instr,
  input wire logic fifo_in_valid,
  input wire logic dma_data_strobe,
  input wire logic dma_channel_ack,
  input wire logic dma_channel_request,
  input wire logic [15:0] host_memory_address,
  input wire logic [15:0] device_control_reg,
  input wire logic [7:0] flags,
  input wire logic data_valid,
  input wire logic fifo_full,
  input wire logic data_available,
  input wire logic int_exec_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence soft_interrupt_op_s;
    instr_valid && instr.expanded_control_field == 4'h5;
  endsequence
  sequence interrupt_enable_op_s;
    instr_valid && instr.expanded_control_field == 4'h6;
  endsequence
  chk_req_cause:
  assert property ($rose(dma_channel_request) |-> $past(instr_valid)
    && host_memory_address == $past(instr.alu_out)) else $error("stray request");
  chk_req_hold:
  assert property (dma_channel_request && !dma_channel_ack |=> dma_channel_request)
    else $error("request dropped");
  chk_req_drop:
  assert property (dma_channel_request && dma_channel_ack |=> !dma_channel_request)
    else $error("request kept");
  chk_dev_load:
  assert property (instr_valid && instr.io_command_field == 2'h3
    |=> device_control_reg == $past(instr.alu_out)) else $error("device load");
  chk_flag_set:
  assert property (instr_valid && instr.expanded_control_field == 4'h4 && !psel
    |=> flags[$past(instr.bit_select)]) else $error("flag set");
  chk_flag_clr:
  assert property (instr_valid && instr.expanded_control_field == 4'h1 && !psel
    |=> !flags[$past(instr.bit_select)]) else $error("flag clear");
  chk_fifo_clear:
  assert property (instr_valid && instr.expanded_control_field == 4'h2 && !fifo_in_valid
    && !dma_data_strobe |=> !data_valid && !fifo_full) else $error("fifo reset");
  chk_int_run:
  assert property (soft_interrupt_op_s ##1 interrupt_enable_op_s |=> int_exec_valid) else $error("interrupt start");
  chk_avail_rise:
  assert property ($rose(data_valid) |-> data_available) else $error("available");
endmodule
bind io_command_expanded_control_field_decoder iocx_checker i_iocx_checker (.*);

// *** tb/dma_host_model.sv ***
// Host memory DMA channel model
`timescale 1ns/1ps
module dma_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dma_channel_request,
  input wire logic dma_write_dir,
  input wire logic [15:0] host_memory_address,
  input wire logic [15:0] dma_write_data,
  input wire logic [2:0] ack_delay,
  output logic dma_channel_ack,
  output logic dma_data_strobe,
  output logic [15:0] dma_read_data
);
  logic [15:0] mem_q [16];
  logic [2:0] wait_q;
  logic [1:0] step_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) mem_q[i] <= 16'h5A00 + 16'(i);
      wait_q <= 3'h0;
      step_q <= 2'h0;
      dma_channel_ack <= 1'h0;
      dma_data_strobe <= 1'h0;
      dma_read_data <= 16'hFFFF;
    end else begin
      dma_channel_ack <= 1'h0;
      dma_data_strobe <= 1'h0;
      // Idle data lines toggle
      dma_read_data <= ~dma_read_data;
      wait_q <= dma_channel_request ? wait_q + 3'h1 : 3'h0;
      if (dma_channel_request && !dma_channel_ack && wait_q >= ack_delay) begin
        dma_channel_ack <= 1'h1;
        step_q <= {1'h0, !dma_write_dir};
        if (dma_write_dir) mem_q[host_memory_address[3:0]] <= dma_write_data;
      end
      if (step_q == 2'h1) step_q <= 2'h2;
      if (step_q == 2'h2) begin
        step_q <= 2'h0;
        dma_data_strobe <= 1'h1;
        dma_read_data <= mem_q[host_memory_address[3:0]];
      end
    end
  end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the decoder
`timescale 1ns/1ps
module tb_top
  import iocx_pkg::*;
;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic instr_valid = 1'h0, fifo_in_valid = 1'h0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  instr_s instr = '0;
  logic [15:0] fifo_in_data = 16'h0, fifo_out_data, host_memory_address, dma_write_data;
  logic [15:0] dma_read_data, device_control_reg, a, w0, w1, w2;
  logic pready, pslverr, fifo_in_ready, data_valid, fifo_full, data_available, irq;
  logic dma_channel_request, dma_write_dir, dma_channel_ack, dma_data_strobe, int_exec_valid;
  logic [7:0] flags, ef = 8'h0;
  logic [2:0] int_exec_index, b, ack_delay = 3'h0;
  int seed = 72026, err_total = 0, cmp_count = 0;
  always #20 pclk = ~pclk;
  io_command_expanded_control_field_decoder i_io_command_expanded_control_field_decoder (.*);
  dma_host_model i_dma_host_model (.*);
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] flag_upd(input logic [7:0] f, input logic [2:0] i,
                                          input logic v);
    flag_upd = f;
    flag_upd[i] = v;
  endfunction
  task automatic close_out;
    $display("compares=%0d errors=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic ins(input logic [1:0] c, input logic [3:0] e, input logic [2:0] s);
    @(posedge pclk);
    instr_valid <= 1'h1;
    instr <= {c, e, s, a};
  endtask
  task automatic idle;
    @(posedge pclk);
    instr_valid <= 1'h0;
    #1;
  endtask
  task automatic push(input logic [15:0] d);
    @(posedge pclk);
    fifo_in_valid <= 1'h1;
    fifo_in_data <= d;
    do @(posedge pclk); while (fifo_in_ready !== 1'h1);
    fifo_in_valid <= 1'h0;
    #1;
  endtask
  task automatic dma(input logic [1:0] c);
    ins(c, 4'h0, 3'h0);
    ack_delay <= 3'($random(seed));
    idle;
    cmp({dma_channel_request, dma_write_dir, host_memory_address}, {1'h1, c[1], a});
    if (!c[0]) cmp(dma_write_data, w0);
    do @(posedge pclk); while ((c[0] ? dma_data_strobe : dma_channel_ack) !== 1'h1);
    #1;
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    #1;
    cmp({flags, data_valid, dma_channel_request}, 10'h0);
    for (int i = 0; i < 8; i++) begin
      b = 3'($random(seed));
      a = 16'($random(seed));
      ins(2'h3, 4'h4, b);
      idle;
      ef = flag_upd(ef, b, 1'h1);
      cmp({flags, device_control_reg}, {ef, a});
      ins(2'h0, 4'h0, ~b);
      idle;
      cmp({flags, device_control_reg}, {ef, a});
      if (i % 2) begin
        ins(2'h0, 4'h1, b);
        idle;
        ef = flag_upd(ef, b, 1'h0);
        cmp(flags, ef);
      end
    end
    apb(1'h0, 12'h004, 32'h0);
    cmp(rd, {24'h0, ef});
    apb(1'h0, 12'h0FC, 32'h0);
    cmp({err, rd}, {1'h1, 32'h0});
    apb(1'h1, 12'h00C, 32'h1);
    w0 = 16'($random(seed));
    w1 = 16'($random(seed));
    w2 = 16'($random(seed));
    push(w0);
    ins(2'h0, 4'h2, 3'h0);
    idle;
    cmp({data_valid, fifo_full}, 2'h0);
    push(w0);
    cmp({data_available, data_valid, fifo_out_data}, {2'h3, w0});
    a = 16'($random(seed));
    dma(2'h2);
    cmp(i_dma_host_model.mem_q[a[3:0]], w0);
    push(w1);
    push(w2);
    cmp(fifo_in_ready, 1'h0);
    a = a ^ 16'h0001;
    dma(2'h1);
    repeat (2) @(posedge pclk);
    #1;
    cmp({fifo_full, fifo_out_data, irq}, {1'h1, w0, 1'h1});
    apb(1'h1, 12'h008, 32'h1F);
    repeat (2) @(posedge pclk);
    #1;
    cmp(irq, 1'h0);
    ins(2'h0, 4'h3, 3'h0);
    idle;
    cmp({fifo_full, fifo_out_data}, {1'h0, w1});
    repeat (2) begin
      ins(2'h0, 4'h3, 3'h0);
      idle;
    end
    cmp({data_valid, fifo_out_data}, {1'h1, i_dma_host_model.mem_q[a[3:0]]});
    ins(2'h0, 4'h2, 3'h0);
    idle;
    cmp({data_valid, fifo_full}, 2'h0);
    a = a ^ 16'h0001;
    dma(2'h1);
    cmp({data_available, fifo_out_data}, {1'h1, w0});
    ins(2'h0, 4'h3, 3'h0);
    idle;
    cmp(data_valid, 1'h0);
    b = 3'($random(seed));
    ins(2'h0, 4'h5, b);
    ins(2'h0, 4'h6, 3'h0);
    idle;
    cmp({int_exec_valid, int_exec_index}, {1'h1, b});
    ins(2'h0, 4'h5, ~b);
    idle;
    cmp(int_exec_valid, 1'h0);
    @(posedge pclk);
    #1;
    cmp({int_exec_valid, int_exec_index}, {1'h1, ~b});
    apb(1'h0, 12'h000, 32'h0);
    cmp({err, rd}, {1'h0, 32'h1});
    close_out;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    close_out;
  end
endmodule
